// ===== inverse_delay_mode_if.sv
// link between the stage logic and its inverse-time arithmetic engine
`timescale 1ns/1ps
interface inverse_delay_mode_if;
  logic [15:0] meas;
  logic [15:0] thr;
  logic [11:0] mult;
  logic [16:0] denom;
  modport eng (input meas, input thr, input mult, output denom);
  modport stage (output meas, output thr, output mult, input denom);
endinterface

// ===== tb_top.sv
// self-checking bench for the four-stage undervoltage trip timer
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      error_cnt++; \
      $display("Error at %0t: got %0h want %0h", $time, a, e); \
    end \
  end
module tb_top;
  // short program cycle, still above the engine's minimum
  localparam int CC = 50;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [15:0] level = 16'h1b58;
  logic [3:0] blk = 4'h0;
  logic [15:0] meas_a;
  logic [15:0] meas_b;
  logic [15:0] meas_c;
  logic [3:0] block_in;
  logic [3:0] start_out;
  logic [3:0] trip_out;
  logic [3:0] blocked_out;
  logic [31:0] event_pulse;
  logic [31:0] event_stamp;
  logic [15:0] event_data;
  logic [31:0] rd;
  int n;
  int error_cnt = 0;
  int comparisons = 0;

  always #5 hclk = ~hclk;

  uv_front_model front (.hclk(hclk), .level(level), .blk(blk),
    .meas_a(meas_a), .meas_b(meas_b), .meas_c(meas_c),
    .block_in(block_in));

  uv_trip_timer #(.CYCLE_CLKS(CC)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .meas_a(meas_a), .meas_b(meas_b), .meas_c(meas_c),
    .block_in(block_in), .setting_group(3'h1), .start_out(start_out),
    .trip_out(trip_out), .blocked_out(blocked_out),
    .event_pulse(event_pulse), .event_stamp(event_stamp),
    .event_data(event_data));

  task automatic bus(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // bounded: a stuck stage must not hang the run
  task automatic wait_for(ref logic [3:0] v, input int i, input logic lv,
    output int cnt);
    cnt = 0;
    do
    begin
      @(posedge hclk);
      cnt++;
    end
    while (v[i] !== lv && cnt < 40 * CC);
    if (cnt >= 40 * CC)
    begin
      error_cnt++;
      $display("Error at %0t: wait ran out", $time);
    end
  endtask

  task automatic settle();
    level <= 16'h1b58;
    blk <= 4'h0;
    repeat (30 * CC) @(posedge hclk);
  endtask

  task automatic t_regs();
    logic [31:0] a [10] = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h10,
      32'h14, 32'h18, 32'h1c, 32'h80, 32'h3c};
    logic [31:0] e [10] = '{32'h69, 32'h1770, 32'h3e8, 32'h8, 32'h5,
      32'h64, 32'hc, 32'hff, 32'h69, 32'h0};
    for (int i = 0; i < 10; i++)
    begin
      bus(1'b0, a[i], 32'h0, rd);
      `CHK(rd, e[i])
      `CHK(hresp, 1'b0)
    end
  endtask

  task automatic t_blk();
    blk <= 4'h2;
    level <= 16'h1388;
    wait_for(blocked_out, 1, 1'b1, n);
    `CHK(start_out[1], 1'b0)
    `CHK(event_pulse[12], 1'b1)
    settle();
  endtask

  task automatic t_dt();
    bus(1'b1, 32'h0c, 32'h3, rd);
    bus(1'b0, 32'h0c, 32'h0, rd);
    `CHK(rd, 32'h3)
    level <= 16'h1388;
    wait_for(start_out, 0, 1'b1, n);
    `CHK(event_pulse[0], 1'b1)
    `CHK(event_data, 16'h1388)
    `CHK(trip_out[0], 1'b0)
    wait_for(trip_out, 0, 1'b1, n);
    `CHK(n, 2 * CC)
    // stamp register has already moved one cycle past the event
    bus(1'b0, 32'h100, 32'h0, rd);
    `CHK(rd, event_stamp + 32'h1)
    level <= 16'h17d4;
    repeat (3 * CC) @(posedge hclk);
    `CHK(trip_out[0], 1'b1)
    settle();
  endtask

  task automatic t_inst();
    bus(1'b1, 32'h0c, 32'h0, rd);
    level <= 16'h1388;
    wait_for(start_out, 0, 1'b1, n);
    `CHK(trip_out[0], 1'b1)
    `CHK(event_pulse[2], 1'b1)
    bus(1'b0, 32'h30, 32'h0, rd);
    `CHK(rd[31:24], 8'h3e)
    settle();
  endtask

  // ratio 5000/6000, a = 1, k = 0.01: twelve ticks of accumulation
  task automatic t_inverse_delay_mode();
    bus(1'b1, 32'h10, 32'h1, rd);
    bus(1'b1, 32'h00, 32'h6a, rd);
    bus(1'b0, 32'h24, 32'h0, rd);
    `CHK(rd, 32'h7ffff)
    level <= 16'h1388;
    wait_for(start_out, 0, 1'b1, n);
    `CHK(trip_out[0], 1'b0)
    wait_for(trip_out, 0, 1'b1, n);
    // start tick may still see a stale zero denominator
    `CHK(n >= 11 * CC && n <= 12 * CC, 1'b1)
    settle();
    bus(1'b1, 32'h00, 32'h69, rd);
    bus(1'b1, 32'h10, 32'h5, rd);
  endtask

  task automatic t_rel();
    bus(1'b1, 32'h0c, 32'h14, rd);
    level <= 16'h1388;
    wait_for(start_out, 0, 1'b1, n);
    repeat (2 * CC) @(posedge hclk);
    level <= 16'h1b58;
    repeat (6 * CC) @(posedge hclk);
    `CHK(start_out[0], 1'b1)
    wait_for(start_out, 0, 1'b0, n);
    `CHK(n > 4 * CC && n < 8 * CC, 1'b1)
    `CHK(trip_out[0], 1'b0)
  endtask

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #400000;
    error_cnt++;
    results();
  end

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_blk();
    t_dt();
    t_inst();
    t_inverse_delay_mode();
    t_rel();
    results();
  end
endmodule

// ===== uv_front_model.sv
// comparator front end and blocking matrix model for the trip timer bench
`timescale 1ns/1ps
module uv_front_model (
  input wire logic hclk,
  input wire logic [15:0] level,
  input wire logic [3:0] blk,
  output logic [15:0] meas_a,
  output logic [15:0] meas_b,
  output logic [15:0] meas_c,
  output logic [3:0] block_in
);
  initial
  begin
    meas_a = 16'h1b58;
    meas_b = 16'h1b58;
    meas_c = 16'h1b58;
    block_in = 4'h0;
  end
  // phase a kept lowest, so it is the one the stage must report
  always @(posedge hclk)
  begin
    meas_a <= level;
    meas_b <= level + 16'h0032;
    meas_c <= level + 16'h0064;
    block_in <= blk;
  end
endmodule

// ===== uv_inverse_delay_mode_engine.sv
// free-running engine for 1 - (um/us)^a in q16
`timescale 1ns/1ps
module uv_inverse_delay_mode_engine (
  input wire logic hclk,
  input wire logic hresetn,
  inverse_delay_mode_if.eng eng
);
`include "uv_trip_consts.svh"
  typedef struct packed {
    uv_trip_pkg::eng_phase_t ph;
    logic [15:0] thr;
    logic lt;
    logic [16:0] rem;
    logic [15:0] quo;
    logic [4:0] cnt;
    logic [16:0] pw;
    logic [16:0] denom;
  } eng_state_t;

  eng_state_t q;
  eng_state_t n;

  always_comb
  begin
    logic [16:0] rem2;
    logic [33:0] prod;
    logic [11:0] ex;
    rem2 = {q.rem[15:0], 1'b0};
    prod = q.pw * {1'b0, q.quo};
    // fractional exponents round to the nearest whole power; a result of 0 runs as power 1
    ex = (eng.mult + `EXP_HALF) / `EXP_UNIT;
    n = q;
    unique case (q.ph)
      uv_trip_pkg::E_LOAD:
      begin
        n.thr = eng.thr;
        n.lt = (eng.meas < eng.thr);
        n.rem = {1'b0, eng.meas};
        n.quo = '0;
        n.cnt = 5'h10;
        n.ph = uv_trip_pkg::E_DIV;
      end
      uv_trip_pkg::E_DIV:
      begin
        if (rem2 >= {1'b0, q.thr})
        begin
          n.rem = rem2 - {1'b0, q.thr};
          n.quo = {q.quo[14:0], 1'b1};
        end
        else
        begin
          n.rem = rem2;
          n.quo = {q.quo[14:0], 1'b0};
        end
        n.cnt = q.cnt - 5'h1;
        if (q.cnt == 5'h1)
        begin
          n.ph = uv_trip_pkg::E_POW;
          n.pw = `Q16_ONE;
          n.cnt = (ex == 12'h0) ? 5'h1 : ex[4:0];
        end
      end
      uv_trip_pkg::E_POW:
      begin
        if (q.cnt == 5'h0)
        begin
          // no pick-up means no progress toward trip
          n.denom = q.lt ? (`Q16_ONE - q.pw) : 17'h0;
          n.ph = uv_trip_pkg::E_LOAD;
        end
        else
        begin
          n.pw = prod[32:16];
          n.cnt = q.cnt - 5'h1;
        end
      end
      default:
        n.ph = uv_trip_pkg::E_LOAD;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else
      q <= n;
  end

  assign eng.denom = q.denom;
endmodule

// ===== uv_trip_consts.svh
// offsets, fields, reset values and timing counts of the undervoltage timer
`ifndef UV_TRIP_CONSTS_SVH
`define UV_TRIP_CONSTS_SVH
`define N_STAGES 4
`define LOG_DEPTH 12
`define LOG_LAST 4'hb
`define CLK_PERIOD_NS 10
`define CYCLE_TIME_MS 5
`define CYCLE_CLKS_DFLT (`CYCLE_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define PRE_TRIG_MS 20
`define PRE_START_MS 200
`define PRE_TRIG_IDX (`PRE_TRIG_MS / `CYCLE_TIME_MS - 1)
`define HIST_DEPTH (`PRE_START_MS / `CYCLE_TIME_MS)
`define CODE_NO 2'h1
`define CODE_YES 2'h2
`define CODE_DT 2'h1
`define CODE_INVERSE_DELAY_MODE 2'h2
`define HYST_PCT 103
`define PCT_FULL 100
`define Q16_ONE 17'h10000
`define K_SHIFT 17
`define EXP_HALF 12'h032
`define EXP_UNIT 12'h064
// word index inside a stage page; page = haddr[8:6], word = haddr[5:2]
`define GLOBAL_PAGE 3'h4
`define REG_CTRL 4'h0
`define REG_PICKUP 4'h1
`define REG_UBLOCK 4'h2
`define REG_DTDLY 4'h3
`define REG_KDIAL 4'h4
`define REG_MULT 4'h5
`define REG_RELDLY 4'h6
`define REG_EVMASK 4'h7
`define REG_STATUS 4'h8
`define REG_REMAIN 4'h9
`define REG_LOGSEL 4'ha
`define REG_LOG0 4'hb
`define REG_LOG1 4'hc
`define REG_LOG2 4'hd
`define REG_LOG3 4'he
`define REG_STAMP 4'h0
`define CTRL_DTYPE_LSB 0
`define CTRL_RELQ_LSB 2
`define CTRL_RSTA_LSB 4
`define CTRL_CONT_LSB 6
`define PICKUP_RST 16'h1770
`define UBLOCK_RST 16'h03e8
`define DT_DEFAULT_MS 40
`define REL_DEFAULT_MS 60
`define DTDLY_RST (`DT_DEFAULT_MS / `CYCLE_TIME_MS)
`define RELDLY_RST (`REL_DEFAULT_MS / `CYCLE_TIME_MS)
`define KDIAL_RST 13'h0005
`define MULT_RST 12'h064
`define EVMASK_RST 8'hff
`endif

// ===== uv_trip_pkg.sv
// types of the undervoltage trip timer
package uv_trip_pkg;
`include "uv_trip_consts.svh"
  typedef enum logic [2:0] {S_IDLE, S_RUN, S_REL, S_TRIP, S_BLK} stage_state_t;
  typedef enum logic [1:0] {E_LOAD, E_DIV, E_POW} eng_phase_t;
  typedef struct packed {
    logic [1:0] dtype;
    logic [1:0] relq;
    logic [1:0] rsta;
    logic [1:0] cont;
    logic [15:0] us;
    logic [15:0] ublk;
    logic [18:0] dly;
    logic [12:0] k;
    logic [11:0] mult;
    logic [14:0] rel;
    logic [7:0] evmask;
    logic [3:0] logsel;
  } stage_cfg_t;
  typedef struct packed {
    stage_state_t state;
    logic [31:0] acc;
    logic [14:0] rc;
    logic pk;
    logic uvb;
  } stage_t;
  typedef struct packed {
    logic [31:0] stamp;
    logic [2:0] sg;
    logic [2:0] phases;
    logic [1:0] ev;
    logic [18:0] remain;
    logic [15:0] pre_trig;
    logic [15:0] fault;
    logic [15:0] pre_start;
  } log_rec_t;
endpackage

// ===== uv_trip_timer.sv
// four-stage undervoltage operate/release timer with events and fault log
// Function
// - instant mode trips together with start
// - fixed delay trips after set delay
// - inverse delay follows k over one minus ratio power
// - delay type code 1 fixed, 2 inverse
// - delay step 5 ms, default 40, zero instant
// - dial and exponent in hundredths, defaults 0.05/1.00
// - release delay 5 ms steps, default 60 ms
// - delayed release holds start through release delay
// - counter clears after release, or at drop
// - optional counting continues during release
// - no trip unless pick-up returns in release
// - defaults hold the counter during release
// - on/off events per signal with masks
// - four independent stages, own event groups
// - events carry timestamp and process value
// - twelve-record rolling log per stage
// - record holds time, event, phases, voltages, group
// - block at pick-up gives blocked, no start
// - pick-up releases at 103 percent of threshold
`timescale 1ns/1ps
module uv_trip_timer #(
  parameter int CYCLE_CLKS = `CYCLE_CLKS_DFLT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [15:0] meas_a,
  input wire logic [15:0] meas_b,
  input wire logic [15:0] meas_c,
  input wire logic [3:0] block_in,
  input wire logic [2:0] setting_group,
  output logic [3:0] start_out,
  output logic [3:0] trip_out,
  output logic [3:0] blocked_out,
  output logic [31:0] event_pulse,
  output logic [31:0] event_stamp,
  output logic [15:0] event_data
);
`include "uv_trip_consts.svh"
  localparam int NS = `N_STAGES;
  localparam int HD = `HIST_DEPTH;

  typedef struct packed {
    logic [18:0] div;
    logic tick;
    logic [31:0] stamp;
    logic [HD-1:0][15:0] hist;
    logic rd_pend;
    logic wr_pend;
    logic [6:0] raddr;
    logic [6:0] waddr;
    logic ready;
    logic resp;
    logic [31:0] rdata;
    uv_trip_pkg::stage_cfg_t [NS-1:0] cfg;
    uv_trip_pkg::stage_t [NS-1:0] st;
    uv_trip_pkg::log_rec_t [NS-1:0][`LOG_DEPTH-1:0] logm;
    logic [NS-1:0][3:0] wp;
    logic [NS-1:0] start;
    logic [NS-1:0] trip;
    logic [NS-1:0] blocked;
    logic [31:0] ev;
    logic [31:0] ev_stamp;
    logic [15:0] ev_data;
  } top_state_t;

  top_state_t q;
  top_state_t n;

  logic [15:0] um_ab;
  logic [15:0] um;
  logic [2:0] phases;
  logic [NS-1:0] pk_now;
  logic [NS-1:0] uvb_now;
  logic [NS-1:0] blkf;
  logic [NS-1:0] is_dt;
  logic [NS-1:0][16:0] denom;
  logic [NS-1:0][31:0] tgt;
  logic [NS-1:0][31:0] inc;
  logic [NS-1:0][18:0] remain;

  function automatic logic [3:0] log_slot(input logic [3:0] wp,
                                          input logic [3:0] sel);
    logic [4:0] t;
    t = {1'b0, wp} + 5'h0b - {1'b0, sel};
    if (t >= 5'h0c)
      t = t - 5'h0c;
    return t[3:0];
  endfunction

  // lowest phase decides pick-up, so release needs all phases up
  assign um_ab = (meas_a < meas_b) ? meas_a : meas_b;
  assign um = (um_ab < meas_c) ? um_ab : meas_c;

  for (genvar gs = 0; gs < NS; gs++)
  begin : g_stage
    inverse_delay_mode_if ifc ();
    assign ifc.meas = um;
    assign ifc.thr = q.cfg[gs].us;
    assign ifc.mult = q.cfg[gs].mult;
    assign denom[gs] = ifc.denom;
    uv_inverse_delay_mode_engine u_eng (
      .hclk(hclk),
      .hresetn(hresetn),
      .eng(ifc.eng)
    );
    assign pk_now[gs] = q.st[gs].pk ?
      (32'(um) * 32'(`PCT_FULL) < 32'(q.cfg[gs].us) * 32'(`HYST_PCT)) :
      (um < q.cfg[gs].us);
    assign uvb_now[gs] = q.st[gs].uvb ? (um < q.cfg[gs].us) :
      ((q.cfg[gs].ublk != 16'h0) && (um < q.cfg[gs].ublk));
    assign blkf[gs] = block_in[gs] | uvb_now[gs];
    assign is_dt[gs] = (q.cfg[gs].dtype != `CODE_INVERSE_DELAY_MODE);
    assign tgt[gs] = is_dt[gs] ? 32'(q.cfg[gs].dly) :
      (32'(q.cfg[gs].k) << `K_SHIFT);
    assign inc[gs] = is_dt[gs] ? 32'h1 : 32'(denom[gs]);
    // inverse mode has no closed-form remaining time; reads all ones
    assign remain[gs] = !is_dt[gs] ? '1 :
      (q.st[gs].acc < tgt[gs]) ? 19'(tgt[gs] - q.st[gs].acc) : '0;
  end

  assign phases = {meas_c < q.cfg[0].us, meas_b < q.cfg[0].us,
                   meas_a < q.cfg[0].us};

  always_comb
  begin
    uv_trip_pkg::stage_t st;
    uv_trip_pkg::stage_cfg_t c;
    uv_trip_pkg::log_rec_t rec;
    logic [31:0] sum;
    logic hit;
    logic [3:0] sig_o;
    logic [3:0] sig_n;
    logic [1:0] evc;
    logic [1:0] ri;
    st = q.st[0];
    c = q.cfg[0];
    rec = '0;
    sum = '0;
    hit = 1'b0;
    sig_o = '0;
    sig_n = '0;
    evc = '0;
    ri = q.raddr[5:4];
    n = q;
    n.ev = '0;
    n.tick = 1'b0;
    n.div = q.div + 19'h1;
    if (q.div == 19'(CYCLE_CLKS - 1))
    begin
      n.div = '0;
      n.tick = 1'b1;
    end
    if (q.tick)
    begin
      n.stamp = q.stamp + 32'h1;
      n.hist = {q.hist[HD-2:0], um};
      n.ev_stamp = q.stamp;
      n.ev_data = um;
      for (int s = 0; s < NS; s++)
      begin
        c = q.cfg[s];
        st = q.st[s];
        st.pk = pk_now[s];
        st.uvb = uvb_now[s];
        sum = q.st[s].acc + inc[s];
        hit = (sum >= tgt[s]);
        unique case (q.st[s].state)
          uv_trip_pkg::S_IDLE:
            if (pk_now[s] && blkf[s])
              st.state = uv_trip_pkg::S_BLK;
            else if (pk_now[s])
            begin
              st.acc = sum;
              st.state = hit ? uv_trip_pkg::S_TRIP : uv_trip_pkg::S_RUN;
            end
          uv_trip_pkg::S_RUN:
            if (blkf[s])
            begin
              st.acc = '0;
              st.state = uv_trip_pkg::S_BLK;
            end
            else if (pk_now[s])
            begin
              st.acc = sum;
              if (hit)
                st.state = uv_trip_pkg::S_TRIP;
            end
            else
            begin
              st.rc = '0;
              if (c.rsta == `CODE_NO)
                st.acc = '0;
              else if (c.cont == `CODE_YES)
                st.acc = sum;
              if (c.rel == 15'h0)
              begin
                st.acc = '0;
                st.state = uv_trip_pkg::S_IDLE;
              end
              else
                st.state = uv_trip_pkg::S_REL;
            end
          uv_trip_pkg::S_REL:
            if (pk_now[s] && blkf[s])
            begin
              st.acc = '0;
              st.state = uv_trip_pkg::S_BLK;
            end
            else if (pk_now[s])
            begin
              st.acc = sum;
              st.state = hit ? uv_trip_pkg::S_TRIP : uv_trip_pkg::S_RUN;
            end
            else
            begin
              st.rc = q.st[s].rc + 15'h1;
              if (st.rc >= c.rel)
              begin
                st.acc = '0;
                st.state = uv_trip_pkg::S_IDLE;
              end
              else if (c.cont == `CODE_YES)
                st.acc = sum;
            end // held otherwise
          uv_trip_pkg::S_TRIP:
            if (!pk_now[s])
            begin
              st.acc = '0;
              st.state = uv_trip_pkg::S_IDLE;
            end
          uv_trip_pkg::S_BLK:
            if (!pk_now[s] || !blkf[s])
            begin
              st.acc = '0;
              st.state = uv_trip_pkg::S_IDLE;
            end
          default:
            st.state = uv_trip_pkg::S_IDLE;
        endcase
        n.st[s] = st;
        n.trip[s] = (st.state == uv_trip_pkg::S_TRIP);
        n.blocked[s] = (st.state == uv_trip_pkg::S_BLK);
        n.start[s] = (st.state == uv_trip_pkg::S_RUN) || n.trip[s] ||
          ((st.state == uv_trip_pkg::S_REL) && (c.relq == `CODE_YES));
        sig_o = {q.st[s].uvb, q.blocked[s], q.trip[s], q.start[s]};
        sig_n = {st.uvb, n.blocked[s], n.trip[s], n.start[s]};
        for (int i = 0; i < 4; i++)
        begin
          n.ev[s*8+i*2] = sig_n[i] & ~sig_o[i] & c.evmask[i*2];
          n.ev[s*8+i*2+1] = ~sig_n[i] & sig_o[i] & c.evmask[i*2+1];
        end
        // one record per cycle; a joint start and trip logs the trip
        evc = (sig_n[1] & ~sig_o[1]) ? 2'h2 :
              (sig_n[0] & ~sig_o[0]) ? 2'h1 :
              (sig_n[2] & ~sig_o[2]) ? 2'h3 : 2'h0;
        if (evc != 2'h0)
        begin
          rec.stamp = q.stamp;
          rec.sg = setting_group;
          rec.phases = phases;
          rec.ev = evc;
          rec.remain = remain[s];
          rec.pre_trig = q.hist[`PRE_TRIG_IDX];
          rec.fault = um;
          rec.pre_start = q.hist[HD-1];
          n.logm[s][q.wp[s]] = rec;
          n.wp[s] = (q.wp[s] == `LOG_LAST) ? 4'h0 : q.wp[s] + 4'h1;
        end
      end
    end
    n.wr_pend = 1'b0;
    n.rd_pend = 1'b0;
    if (q.wr_pend && !q.waddr[6])
    begin
      c = q.cfg[q.waddr[5:4]];
      unique case (q.waddr[3:0])
        `REG_CTRL:
        begin
          c.dtype = hwdata[`CTRL_DTYPE_LSB +: 2];
          c.relq = hwdata[`CTRL_RELQ_LSB +: 2];
          c.rsta = hwdata[`CTRL_RSTA_LSB +: 2];
          c.cont = hwdata[`CTRL_CONT_LSB +: 2];
        end
        `REG_PICKUP: c.us = hwdata[15:0];
        `REG_UBLOCK: c.ublk = hwdata[15:0];
        `REG_DTDLY: c.dly = hwdata[18:0];
        `REG_KDIAL: c.k = hwdata[12:0];
        `REG_MULT: c.mult = hwdata[11:0];
        `REG_RELDLY: c.rel = hwdata[14:0];
        `REG_EVMASK: c.evmask = hwdata[7:0];
        `REG_LOGSEL:
          c.logsel = (hwdata[3:0] > `LOG_LAST) ? `LOG_LAST : hwdata[3:0];
        default: ;
      endcase
      n.cfg[q.waddr[5:4]] = c;
    end
    if (q.rd_pend)
    begin
      c = q.cfg[ri];
      rec = q.logm[ri][log_slot(q.wp[ri], c.logsel)];
      n.ready = 1'b1;
      n.rdata = '0;
      if (q.raddr[6:4] == `GLOBAL_PAGE && q.raddr[3:0] == `REG_STAMP)
        n.rdata = q.stamp;
      else if (!q.raddr[6])
        unique case (q.raddr[3:0])
          `REG_CTRL: n.rdata = {24'h0, c.cont, c.rsta, c.relq, c.dtype};
          `REG_PICKUP: n.rdata = {16'h0, c.us};
          `REG_UBLOCK: n.rdata = {16'h0, c.ublk};
          `REG_DTDLY: n.rdata = {13'h0, c.dly};
          `REG_KDIAL: n.rdata = {19'h0, c.k};
          `REG_MULT: n.rdata = {20'h0, c.mult};
          `REG_RELDLY: n.rdata = {17'h0, c.rel};
          `REG_EVMASK: n.rdata = {24'h0, c.evmask};
          `REG_STATUS: n.rdata = {24'h0, q.st[ri].state, q.st[ri].pk,
            q.st[ri].uvb, q.blocked[ri], q.trip[ri], q.start[ri]};
          `REG_REMAIN: n.rdata = {13'h0, remain[ri]};
          `REG_LOGSEL: n.rdata = {28'h0, c.logsel};
          `REG_LOG0: n.rdata = rec.stamp;
          `REG_LOG1: n.rdata = {rec.sg, rec.phases, rec.ev, 5'h0, rec.remain};
          `REG_LOG2: n.rdata = {rec.pre_trig, rec.fault};
          `REG_LOG3: n.rdata = {16'h0, rec.pre_start};
          default: n.rdata = '0;
        endcase
    end
    // reads take one wait state so a write just before is visible
    if (hsel && hready && htrans[1])
    begin
      n.wr_pend = hwrite;
      n.rd_pend = !hwrite;
      n.waddr = haddr[8:2];
      n.raddr = haddr[8:2];
      n.ready = hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.ready <= 1'b1;
      for (int s = 0; s < NS; s++)
      begin
        q.cfg[s].dtype <= `CODE_DT;
        q.cfg[s].relq <= `CODE_YES;
        q.cfg[s].rsta <= `CODE_YES;
        q.cfg[s].cont <= `CODE_NO;
        q.cfg[s].us <= `PICKUP_RST;
        q.cfg[s].ublk <= `UBLOCK_RST;
        q.cfg[s].dly <= 19'(`DTDLY_RST);
        q.cfg[s].k <= `KDIAL_RST;
        q.cfg[s].mult <= `MULT_RST;
        q.cfg[s].rel <= 15'(`RELDLY_RST);
        q.cfg[s].evmask <= `EVMASK_RST;
      end
    end
    else
      q <= n;
  end

  assign hreadyout = q.ready;
  assign hrdata = q.rdata;
  assign hresp = q.resp;
  assign start_out = q.start;
  assign trip_out = q.trip;
  assign blocked_out = q.blocked;
  assign event_pulse = q.ev;
  assign event_stamp = q.ev_stamp;
  assign event_data = q.ev_data;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_INSTANT: assert property (
    q.tick && q.st[0].state == uv_trip_pkg::S_IDLE && pk_now[0] &&
    !blkf[0] && is_dt[0] && q.cfg[0].dly == 19'h0
    |=> q.trip[0] && q.start[0])
    else $error("instant stage did not trip with start");
  AST_DT_TRIP: assert property (
    $rose(q.trip[0]) && is_dt[0] |-> q.st[0].acc >= 32'(q.cfg[0].dly))
    else $error("fixed delay trip came early");
  AST_INVERSE_DELAY_MODE_RATE: assert property (
    q.tick && q.st[0].state == uv_trip_pkg::S_RUN && pk_now[0] &&
    !blkf[0] && !is_dt[0]
    |=> q.st[0].acc == $past(q.st[0].acc) + $past(32'(denom[0])))
    else $error("inverse accumulation step wrong");
  AST_REL_START: assert property (
    q.st[0].state == uv_trip_pkg::S_REL
    |-> q.start[0] == (q.cfg[0].relq == `CODE_YES))
    else $error("start level wrong during release");
  AST_REL_NO_TRIP: assert property (
    q.st[0].state == uv_trip_pkg::S_REL |-> !q.trip[0])
    else $error("trip during release");
  AST_BLOCK: assert property (
    q.tick && q.st[0].state == uv_trip_pkg::S_IDLE && pk_now[0] && blkf[0]
    |=> q.blocked[0] && !q.start[0])
    else $error("blocked pick-up produced start");
  AST_FREEZE: assert property (
    q.tick && q.st[0].state == uv_trip_pkg::S_REL && !pk_now[0] &&
    q.cfg[0].cont != `CODE_YES && q.st[0].rc + 15'h1 < q.cfg[0].rel
    |=> $stable(q.st[0].acc))
    else $error("counter moved while held in release");
  AST_EV_MASK: assert property (
    q.ev[0] |-> q.cfg[0].evmask[0] && q.start[0] && !$past(q.start[0], 2))
    else $error("masked or spurious start event");
  AST_STAMP: assert property (
    q.tick |=> q.stamp == $past(q.stamp) + 32'h1 ##0
    q.ev_stamp == $past(q.stamp))
    else $error("timestamp did not advance");
  COV_INVERSE_DELAY_MODE_TRIP: cover property ($rose(q.trip[0]) && !is_dt[0]);
  COV_REL_RESUME: cover property (
    q.st[0].state == uv_trip_pkg::S_REL ##1
    q.st[0].state == uv_trip_pkg::S_RUN);
  COV_BLOCKED: cover property ($rose(q.blocked[0]));
endmodule
